// File: rtl/dsr_pkg.sv
// Package for the debug system reset request block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`default_nettype none
package dsr_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFF_SYS_RST_REQ = 12'h310;
  localparam logic [11:0] OFF_SYS_RST_ACK = 12'h314;
  localparam logic [11:0] OFF_AUTH_STATUS = 12'hFB8;
  localparam logic [11:0] OFF_CIDENT_0    = 12'hFF0;
  localparam logic [11:0] OFF_CIDENT_1    = 12'hFF4;
  localparam logic [11:0] OFF_CIDENT_2    = 12'hFF8;
  localparam logic [11:0] OFF_CIDENT_3    = 12'hFFC;
  // ==========================================================
  // Field positions
  localparam int REQ_BIT      = 1;
  localparam int ACK_BIT      = 1;
  localparam int AUTH_ROOT_NONINV_LO  = 26;
  localparam int AUTH_ROOT_INV_LO     = 24;
  localparam int AUTH_REALM_NONINV_LO = 14;
  localparam int AUTH_REALM_INV_LO    = 12;
  localparam int AUTH_SEC_NONINV_LO   = 6;
  localparam int AUTH_SEC_INV_LO      = 4;
  localparam int AUTH_NS_NONINV_LO    = 2;
  localparam int AUTH_NS_INV_LO       = 0;
  // ==========================================================
  // Fixed identification values
  localparam logic [7:0] PREAMBLE_BYTE_0   = 8'h0D;
  localparam logic [3:0] PREAMBLE_NIBBLE_1 = 4'h0;
  localparam logic [3:0] CLASS_ROM_TABLE   = 4'h9;
  localparam logic [7:0] PREAMBLE_BYTE_2   = 8'h05;
  localparam logic [7:0] PREAMBLE_BYTE_3   = 8'hB1;
  // ==========================================================
  // Reset values and timing
  localparam logic       REQ_RESET        = 1'b0;
  localparam logic [3:0] DBG_PULSE_CYCLES = 4'h4;
  // ==========================================================
  // Security configuration of the system
  typedef enum logic [1:0] {
    DSR_SEC_NONE   = 2'h0,
    DSR_SEC_SPLIT  = 2'h1,
    DSR_SEC_ROOT   = 2'h3
  } dsr_sec_t;
  // Reset sequencer states, Gray along the path
  typedef enum logic [1:0] {
    DSR_IDLE  = 2'h0,
    DSR_PULSE = 2'h1,
    DSR_HOLD  = 2'h3,
    DSR_DRAIN = 2'h2
  } dsr_state_t;
endpackage
`default_nettype wire

// File: rtl/dsr_sync.sv
// Three-stage synchroniser with agreement filter for pin levels.
// Assumes input is asynchronous to core_clk.
`default_nettype none
module dsr_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dsr_sync_t;
  dsr_sync_t st;
  dsr_sync_t next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Change counts only when stages two and three agree
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end
  assign level = st.lvl;
endmodule
`default_nettype wire

// File: rtl/dsr_top.sv
// Debug system reset request block with auth status and component id.
// Assumes a classic Wishbone master and asynchronous auth pin levels.
//
// Behaviour
// - Request bit set holds system reset asserted for its whole duration.
// - Debug logic may be reset once but is released straight after.
// - System reset or debug reset clears request; system then released.
// - With root extension, requests ignored while root invasive off.
// - Split worlds without root: ignored while secure invasive off.
// - No security split: ignored while invasive debug is off.
// - Read-only auth status register at offset FB8 shows levels.
// - Unprivileged and hypervisor level fields always read zero.
// - Root fields at 27:26 and 25:24; bits 31:28 read zero.
// - Realm fields at 15:14 and 13:12.
// - Secure and non-secure fields at 7:6, 5:4, 3:2, 1:0.
// - Without gating need, all auth fields may read zero.
// - Four read-only id registers at FF0..FFC, bits 31:8 zero.
// - Id registers return fixed preamble bytes and ROM class nibble.
//
// The Wishbone interface to the registers was left to the implementer.
`default_nettype none
module dsr_top
  import dsr_pkg::*;
#(
  parameter dsr_pkg::dsr_sec_t SEC_MODE   = dsr_pkg::DSR_SEC_SPLIT,
  parameter bit                AUTH_GATED = 1'b1,
  parameter bit                WRITE_GATE = 1'b0
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [dsr_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [dsr_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [dsr_pkg::DATA_W-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           wb_err_o,
  input  wire logic                      invasiveEn,
  input  wire logic                      nonInvasiveEn,
  input  wire logic                      secInvasiveEn,
  input  wire logic                      secNonInvasiveEn,
  input  wire logic                      rootInvasiveEn,
  input  wire logic                      rootNonInvasiveEn,
  input  wire logic                      realmInvasiveEn,
  input  wire logic                      realmNonInvasiveEn,
  input  wire logic                      sysResetDone,
  input  wire logic                      sysResetActive,
  input  wire logic                      dbgResetActive,
  output logic                           sysResetReq,
  output logic                           dbgResetPulse
);
  import dsr_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [7:0] authPins;
  logic [7:0] authLvl;
  logic       sysRstLvl;
  logic       dbgRstLvl;
  logic       sysDoneLvl;
  assign authPins = {rootNonInvasiveEn, rootInvasiveEn, realmNonInvasiveEn,
                     realmInvasiveEn, secNonInvasiveEn, secInvasiveEn,
                     nonInvasiveEn, invasiveEn};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gAuth
      dsr_sync #(.RESET_VAL(1'b0)) uSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinIn    (authPins[gi]),
        .level    (authLvl[gi])
      );
    end
  endgenerate

  dsr_sync #(.RESET_VAL(1'b0)) uSysRst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (sysResetActive),
    .level    (sysRstLvl)
  );
  dsr_sync #(.RESET_VAL(1'b0)) uDbgRst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (dbgResetActive),
    .level    (dbgRstLvl)
  );
  dsr_sync #(.RESET_VAL(1'b0)) uSysDone (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (sysResetDone),
    .level    (sysDoneLvl)
  );

  // ==========================================================
  // Authentication decode
  function automatic logic [1:0] authField(input logic en);
    if (!AUTH_GATED) begin
      authField = 2'h0;
    end else begin
      authField = en ? 2'h3 : 2'h2;
    end
  endfunction

  logic reqAllowed;
  always_comb begin
    unique case (SEC_MODE)
      DSR_SEC_ROOT:  reqAllowed = authLvl[6];
      DSR_SEC_SPLIT: reqAllowed = authLvl[2];
      DSR_SEC_NONE:  reqAllowed = authLvl[0];
      default:       reqAllowed = 1'b0;
    endcase
    if (!AUTH_GATED) begin
      reqAllowed = 1'b1;
    end
  end

  logic [DATA_W-1:0] authWord;
  always_comb begin
    authWord = '0;
    if (SEC_MODE == DSR_SEC_ROOT) begin
      authWord[AUTH_ROOT_NONINV_LO +: 2]  = authField(authLvl[7]);
      authWord[AUTH_ROOT_INV_LO +: 2]     = authField(authLvl[6]);
      authWord[AUTH_REALM_NONINV_LO +: 2] = authField(authLvl[5]);
      authWord[AUTH_REALM_INV_LO +: 2]    = authField(authLvl[4]);
    end
    if (SEC_MODE != DSR_SEC_NONE) begin
      authWord[AUTH_SEC_NONINV_LO +: 2] = authField(authLvl[3]);
      authWord[AUTH_SEC_INV_LO +: 2]    = authField(authLvl[2]);
    end
    authWord[AUTH_NS_NONINV_LO +: 2] = authField(authLvl[1]);
    authWord[AUTH_NS_INV_LO +: 2]    = authField(authLvl[0]);
    if (!AUTH_GATED) begin
      authWord = '0;
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    dsr_state_t        fsm;
    logic              req;
    logic              ack;
    logic [3:0]        pulseCnt;
    logic              busAck;
    logic              busErr;
    logic [DATA_W-1:0] rdData;
  } dsr_top_t;

  dsr_top_t st;
  dsr_top_t next_st;

  logic busReq;
  logic wrReq;
  logic known;
  logic [DATA_W-1:0] rdMux;
  assign busReq = wb_cyc_i && wb_stb_i && !st.busAck && !st.busErr;
  assign wrReq  = busReq && wb_we_i;

  // ==========================================================
  // Read decode
  always_comb begin
    known = 1'b1;
    rdMux = '0;
    unique case (wb_adr_i)
      OFF_SYS_RST_REQ: rdMux[REQ_BIT] = st.req;
      OFF_SYS_RST_ACK: rdMux[ACK_BIT] = st.ack;
      OFF_AUTH_STATUS: rdMux = authWord;
      OFF_CIDENT_0:    rdMux[7:0] = PREAMBLE_BYTE_0;
      OFF_CIDENT_1:    rdMux[7:0] = {CLASS_ROM_TABLE, PREAMBLE_NIBBLE_1};
      OFF_CIDENT_2:    rdMux[7:0] = PREAMBLE_BYTE_2;
      OFF_CIDENT_3:    rdMux[7:0] = PREAMBLE_BYTE_3;
      default:         known = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.busAck = busReq && known;
    next_st.busErr = busReq && !known;
    next_st.rdData = (busReq && known && !wb_we_i) ? rdMux : '0;
    // Only the request register accepts writes
    if (wrReq && wb_adr_i == OFF_SYS_RST_REQ && wb_sel_i[0]) begin
      if (!(WRITE_GATE && !reqAllowed)) begin
        next_st.req = wb_dat_i[REQ_BIT];
      end
    end
    if (sysRstLvl || dbgRstLvl) begin
      next_st.req = REQ_RESET;
    end
    unique case (st.fsm)
      DSR_IDLE: begin
        next_st.ack = 1'b0;
        if (st.req && reqAllowed) begin
          next_st.fsm      = DSR_PULSE;
          next_st.pulseCnt = DBG_PULSE_CYCLES;
        end
      end
      DSR_PULSE: begin
        if (st.pulseCnt == 4'h1) begin
          next_st.fsm = DSR_HOLD;
        end
        next_st.pulseCnt = st.pulseCnt - 4'h1;
      end
      DSR_HOLD: begin
        next_st.ack = sysDoneLvl;
        if (!st.req || !reqAllowed) begin
          next_st.fsm = DSR_DRAIN;
        end
      end
      DSR_DRAIN: begin
        next_st.ack = 1'b0;
        next_st.fsm = DSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{DSR_IDLE, REQ_RESET, 1'b0, 4'h0, 1'b0, 1'b0, '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // Hold system reset throughout
  assign sysResetReq   = (st.fsm == DSR_PULSE) || (st.fsm == DSR_HOLD);
  assign dbgResetPulse = (st.fsm == DSR_PULSE);
  assign wb_ack_o      = st.busAck;
  assign wb_err_o      = st.busErr;
  assign wb_dat_o      = st.rdData;

  // ==========================================================
  // Checks
  sequence sqReqSeen;
    st.req && reqAllowed && st.fsm == DSR_IDLE;
  endsequence
  sequence sqPulse;
    dbgResetPulse [*4] ##1 !dbgResetPulse;
  endsequence

  AST_REQ_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.fsm == DSR_HOLD && st.req && reqAllowed |=> sysResetReq)
    else $error("system reset dropped while request held");
  AST_DBG_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    sqReqSeen |=> sqPulse)
    else $error("debug reset pulse wrong length");
  AST_CLEAR_RST: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sysRstLvl || dbgRstLvl) |=> !st.req ##1 !sysResetReq)
    else $error("request not cleared by reset");
  AST_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.fsm == DSR_IDLE && !reqAllowed |=> !sysResetReq)
    else $error("request acted on while gated");
  AST_SPLIT_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    SEC_MODE == DSR_SEC_SPLIT && AUTH_GATED && !authLvl[2]
      && st.fsm == DSR_IDLE |=> !dbgResetPulse)
    else $error("secure gate ignored");
  AST_AUTH_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    authWord[31:28] == 4'h0 && authWord[23:16] == 8'h00
      && authWord[11:8] == 4'h0)
    else $error("unsupported auth fields not zero");
  AST_ID_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    busReq && !wb_we_i && wb_adr_i == OFF_CIDENT_1
      |=> wb_ack_o && wb_dat_o == 32'h00000090)
    else $error("class id read wrong");
  AST_ID_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrReq && wb_adr_i != OFF_SYS_RST_REQ |=> st.req == $past(st.req))
    else $error("read-only write changed state");
  AST_ACK_DROP: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.fsm == DSR_DRAIN |=> !st.ack ##1 !st.ack)
    else $error("ack did not fall after release");
endmodule
`default_nettype wire

// File: testbench/dsr_rst_ctrl_model.sv
// System reset controller model for the reset request block.
// Assumes the bench commands external resets and the answer delay.
`default_nettype none
module dsr_rst_ctrl_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sysResetReq,
  input  wire logic [3:0] respDelay,
  input  wire logic       applySys,
  input  wire logic       applyDbg,
  output logic            sysResetDone,
  output logic            sysResetActive,
  output logic            dbgResetActive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;
  // ========================================
  // Hold handshake
  // done only while held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt      <= 4'h0;
      sysResetDone <= 1'b0;
    end else if (!sysResetReq) begin
      waitCnt      <= 4'h0;
      sysResetDone <= 1'b0;
    end else if (waitCnt < respDelay) begin
      waitCnt <= waitCnt + 4'h1;
    end else begin
      sysResetDone <= 1'b1;
    end
  end
  // ========================================
  // External resets
  // only when commanded
  assign sysResetActive = applySys;
  assign dbgResetActive = applyDbg;
endmodule
`default_nettype wire

// File: testbench/tb_debug_system_reset_request.sv
// Self-checking bench for the debug system reset request block.
// Assumes the reset controller model; two extra instances cover the
// root and plain security modes, selected by tgt on the shared bus.
`default_nettype none
module tb_debug_system_reset_request import dsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wbCyc    = 1'b0;
  logic        wbStb    = 1'b0;
  logic        wbWe     = 1'b0;
  logic [11:0] wbAdr    = 12'h000;
  logic [3:0]  wbSel    = 4'h0;
  logic [31:0] wbWdat   = 32'h0;
  logic [31:0] wbRdat;
  logic        wbAck;
  logic        wbErr;
  logic [1:0]  tgt      = 2'h0;
  logic [31:0] mainRdat;
  logic [31:0] rootRdat;
  logic [31:0] plainRdat;
  logic        mainAck;
  logic        rootAck;
  logic        plainAck;
  logic        mainErr;
  logic        rootErr;
  logic        plainErr;
  logic        rootReq;
  logic        plainReq;
  logic        tgtReq;
  logic [7:0]  authEn   = 8'hFF;
  logic [3:0]  respDelay = 4'h0;
  logic        applySys = 1'b0;
  logic        applyDbg = 1'b0;
  logic        sysResetDone;
  logic        sysResetActive;
  logic        dbgResetActive;
  logic        sysResetReq;
  logic        dbgResetPulse;
  int          fails    = 0;
  int          checked  = 0;
  // ========================================
  // Design and partner
  dsr_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc && tgt == 2'h0),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbWdat), .wb_dat_o(mainRdat), .wb_ack_o(mainAck),
    .wb_err_o(mainErr),
    .invasiveEn(authEn[0]), .nonInvasiveEn(authEn[1]),
    .secInvasiveEn(authEn[2]), .secNonInvasiveEn(authEn[3]),
    .rootInvasiveEn(authEn[4]), .rootNonInvasiveEn(authEn[5]),
    .realmInvasiveEn(authEn[6]), .realmNonInvasiveEn(authEn[7]),
    .sysResetDone(sysResetDone), .sysResetActive(sysResetActive),
    .dbgResetActive(dbgResetActive), .sysResetReq(sysResetReq),
    .dbgResetPulse(dbgResetPulse)
  );
  // Other security modes, no reset controller behind them
  dsr_top #(.SEC_MODE(DSR_SEC_ROOT)) u_dut_root (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc && tgt == 2'h1),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbWdat), .wb_dat_o(rootRdat), .wb_ack_o(rootAck),
    .wb_err_o(rootErr), .invasiveEn(authEn[0]), .nonInvasiveEn(authEn[1]),
    .secInvasiveEn(authEn[2]), .secNonInvasiveEn(authEn[3]),
    .rootInvasiveEn(authEn[4]), .rootNonInvasiveEn(authEn[5]),
    .realmInvasiveEn(authEn[6]), .realmNonInvasiveEn(authEn[7]),
    .sysResetDone(1'b0), .sysResetActive(1'b0), .dbgResetActive(1'b0),
    .sysResetReq(rootReq), .dbgResetPulse()
  );
  dsr_top #(.SEC_MODE(DSR_SEC_NONE)) u_dut_plain (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc && tgt == 2'h2),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbWdat), .wb_dat_o(plainRdat), .wb_ack_o(plainAck),
    .wb_err_o(plainErr), .invasiveEn(authEn[0]), .nonInvasiveEn(authEn[1]),
    .secInvasiveEn(authEn[2]), .secNonInvasiveEn(authEn[3]),
    .rootInvasiveEn(authEn[4]), .rootNonInvasiveEn(authEn[5]),
    .realmInvasiveEn(authEn[6]), .realmNonInvasiveEn(authEn[7]),
    .sysResetDone(1'b0), .sysResetActive(1'b0), .dbgResetActive(1'b0),
    .sysResetReq(plainReq), .dbgResetPulse()
  );
  assign wbRdat = (tgt == 2'h1) ? rootRdat :
                  (tgt == 2'h2) ? plainRdat : mainRdat;
  assign wbAck  = (tgt == 2'h1) ? rootAck :
                  (tgt == 2'h2) ? plainAck : mainAck;
  assign wbErr  = (tgt == 2'h1) ? rootErr :
                  (tgt == 2'h2) ? plainErr : mainErr;
  assign tgtReq = (tgt == 2'h1) ? rootReq : plainReq;
  dsr_rst_ctrl_model u_rstc (
    .core_clk(core_clk), .rst_n(rst_n), .sysResetReq(sysResetReq),
    .respDelay(respDelay), .applySys(applySys), .applyDbg(applyDbg),
    .sysResetDone(sysResetDone), .sysResetActive(sysResetActive),
    .dbgResetActive(dbgResetActive)
  );
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // ========================================
  // Reporting
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  // ========================================
  // Bus cycles, no fixed answer time assumed
  task automatic wbXfer(input logic we, input logic [11:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= 4'hF;
    wbWdat <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20);
    rd  = wbRdat;
    err = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    if (wbAck !== 1'b1 && wbErr !== 1'b1) begin
      chk("bus answer", 32'h1, 32'h0);
      end_of_test;
    end
  endtask
  task automatic rdChk(input string name, input logic [11:0] adr,
                       input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    wbXfer(1'b0, adr, 32'h0, d, e);
    chk(name, exp, d);
  endtask
  task automatic waitReq(input logic lvl);
    int n;
    n = 0;
    while (sysResetReq !== lvl && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk("hold level", {31'h0, lvl}, {31'h0, sysResetReq});
  endtask
  task automatic pollAck(input logic lvl);
    logic [31:0] d;
    logic        e;
    int          n;
    n = 0;
    do begin
      wbXfer(1'b0, OFF_SYS_RST_ACK, 32'h0, d, e);
      n++;
    end while (d[ACK_BIT] !== lvl && n < 30);
    chk("ack bit", {31'h0, lvl}, {31'h0, d[ACK_BIT]});
  endtask
  // ========================================
  // Scenarios
  task automatic scIdent;
    logic [31:0] d;
    logic        e;
    rdChk("ident0", OFF_CIDENT_0, 32'h0000000D);
    rdChk("ident1", OFF_CIDENT_1, 32'h00000090);
    rdChk("ident2", OFF_CIDENT_2, 32'h00000005);
    rdChk("ident3", OFF_CIDENT_3, 32'h000000B1);
    wbXfer(1'b1, OFF_CIDENT_1, 32'hFFFFFFFF, d, e);
    rdChk("ident1 kept", OFF_CIDENT_1, 32'h00000090);
    wbXfer(1'b0, 12'h000, 32'h0, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask
  task automatic scAuth;
    logic [31:0] d;
    logic        e;
    rdChk("auth all on", OFF_AUTH_STATUS, 32'h000000FF);
    // Root and realm inputs must not show in this mode
    authEn <= 8'h66;
    repeat (8) @(posedge core_clk);
    rdChk("auth mixed", OFF_AUTH_STATUS, 32'h000000BE);
    wbXfer(1'b1, OFF_AUTH_STATUS, 32'hFFFFFFFF, d, e);
    rdChk("auth kept", OFF_AUTH_STATUS, 32'h000000BE);
    authEn <= 8'hFF;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic scHold(input logic [3:0] dly);
    logic [31:0] d;
    logic        e;
    int          pulse;
    int          gap;
    pulse = 0;
    gap   = 0;
    respDelay <= dly;
    wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h2, d, e);
    waitReq(1'b1);
    repeat (20) begin
      if (dbgResetPulse === 1'b1) pulse++;
      if (sysResetReq !== 1'b1) gap++;
      @(posedge core_clk);
    end
    chk("debug pulse", {28'h0, DBG_PULSE_CYCLES}, 32'(pulse));
    chk("hold gaps", 32'h0, 32'(gap));
    pollAck(1'b1);
    chk("held at ack", 32'h1, {31'h0, sysResetReq});
    wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h0, d, e);
    pollAck(1'b0);
    waitReq(1'b0);
  endtask
  task automatic scGate;
    logic [31:0] d;
    logic        e;
    int          hits;
    hits = 0;
    authEn <= 8'hFB;
    repeat (8) @(posedge core_clk);
    wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h2, d, e);
    repeat (12) begin
      @(posedge core_clk);
      if (sysResetReq !== 1'b0) hits++;
    end
    chk("gated hold", 32'h0, 32'(hits));
    rdChk("gated bit", OFF_SYS_RST_REQ, 32'h2);
    wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h0, d, e);
    authEn <= 8'hFF;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic scClear;
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 2; i++) begin
      wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h2, d, e);
      waitReq(1'b1);
      applySys <= (i == 0);
      applyDbg <= (i == 1);
      repeat (6) @(posedge core_clk);
      applySys <= 1'b0;
      applyDbg <= 1'b0;
      waitReq(1'b0);
      rdChk("request cleared", OFF_SYS_RST_REQ, 32'h0);
    end
  endtask
  task automatic scMode(input logic [1:0] t, input logic [31:0] expAuth,
                        input logic [7:0] onEn);
    logic [31:0] d;
    logic        e;
    int          hits;
    hits = 0;
    authEn <= 8'h66;
    tgt    <= t;
    repeat (8) @(posedge core_clk);
    wbXfer(1'b0, OFF_AUTH_STATUS, 32'h0, d, e);
    chk("mode root fields", expAuth & 32'hFF000000,
        d & 32'hFF000000);
    chk("mode realm fields", expAuth & 32'h0000FF00,
        d & 32'h0000FF00);
    chk("mode low fields", expAuth & 32'h00FF00FF,
        d & 32'h00FF00FF);
    wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h2, d, e);
    repeat (12) begin
      @(posedge core_clk);
      if (tgtReq !== 1'b0) hits++;
    end
    chk("mode gated", 32'h0, 32'(hits));
    authEn <= onEn;
    repeat (12) @(posedge core_clk);
    chk("mode allowed", 32'h1, {31'h0, tgtReq});
    wbXfer(1'b1, OFF_SYS_RST_REQ, 32'h0, d, e);
    repeat (4) @(posedge core_clk);
    chk("mode released", 32'h0, {31'h0, tgtReq});
    authEn <= 8'hFF;
    tgt    <= 2'h0;
    repeat (8) @(posedge core_clk);
  endtask
  // ========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    scIdent;
    scAuth;
    scHold(4'h0);
    scHold(4'h6);
    scGate;
    scClear;
    scMode(2'h1, 32'h0E00B0BE, 8'h76);
    scMode(2'h2, 32'h0000000E, 8'h67);
    end_of_test;
  end
endmodule
`default_nettype wire
